// [hdl/clpm_ctrl.sv]
/*
 clock source selection, gating and reduced power mode control.
 assumes oscillator edges arrive as synchronous one-cycle enable pulses
 on clk_i; clock outputs are enable pulses for the clock tree.
*/
`timescale 1ns/1ps
`include "clpm_regs.svh"

module clpm_ctrl #(
   parameter int NPERIPH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [`CLPM_ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   input wire logic fro_tick_i,
   input wire logic lposc_tick_i,
   input wire logic ext_clk_tick_i,
   input wire logic ext_clk_assigned_i,
   input wire logic clock_output_function_assigned_i,
   input wire logic sleep_req_i,
   input wire clpm_pkg::clpm_wake_t wake_int_i,
   input wire clpm_pkg::clpm_wake_t wake_ctl_en_i,
   input wire logic any_int_i,
   output logic core_clk_en_o,
   output logic main_clk_en_o,
   output logic [NPERIPH-1:0] periph_clk_en_o,
   output logic clock_output_function_o,
   output clpm_pkg::clpm_power_t power_o,
   output logic [1:0] fro_rate_o,
   output logic fro_div2_o
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [2:0] frocfg_reg;
   clpm_pkg::clpm_main_src_t mainsel_reg;
   logic [7:0] corediv_reg;
   logic [NPERIPH-1:0] gates_reg;
   logic [2:0] runpwr_reg;
   clpm_pkg::clpm_out_src_t outsel_reg;
   clpm_pkg::clpm_mode_t pwrmode_reg;
   clpm_pkg::clpm_wake_t wakeen_reg;
   logic [2:0] sleepcfg_reg;
   logic [7:0] perdiv_reg;
   clpm_pkg::clpm_state_t state_reg;
   clpm_pkg::clpm_main_src_t cur_src_reg;
   logic [7:0] core_cnt_reg;
   logic [7:0] per_cnt_reg;
   logic [3:0] settle_reg;
   logic fro_half_reg;
   logic [31:0] rdata_next;

   function automatic logic wr_hit(input logic [`CLPM_ADDR_W-1:0] ofs);
      wr_hit = wr_i && (addr_i == ofs);
   endfunction

   // ------------------------------------------------------------
   // clock selection registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frocfg_reg <= `CLPM_RST_FROCFG;
         mainsel_reg <= clpm_pkg::CLPM_SRC_FRO;
         corediv_reg <= `CLPM_RST_COREDIV;
         outsel_reg <= clpm_pkg::CLPM_OUT_NONE;
         perdiv_reg <= `CLPM_RST_PERDIV;
      end else begin
         if (wr_hit(`CLPM_OFS_FROCFG))
            frocfg_reg <= wdata_i[2:0];
         if (wr_hit(`CLPM_OFS_MAINSEL))
            mainsel_reg <= clpm_pkg::clpm_main_src_t'(wdata_i[2:0]);
         if (wr_hit(`CLPM_OFS_COREDIV))
            corediv_reg <= wdata_i[7:0];
         if (wr_hit(`CLPM_OFS_OUTSEL))
            outsel_reg <= clpm_pkg::clpm_out_src_t'(wdata_i[2:0]);
         if (wr_hit(`CLPM_OFS_PERDIV))
            perdiv_reg <= wdata_i[7:0];
      end
   end

   // ------------------------------------------------------------
   // peripheral gate register
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         gates_reg <= '1;
      else if (wr_hit(`CLPM_OFS_GATES))
         gates_reg <= wdata_i[NPERIPH-1:0];
   end

   // ------------------------------------------------------------
   // power mode registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         runpwr_reg <= `CLPM_RST_RUNPWR;
         pwrmode_reg <= clpm_pkg::CLPM_MODE_SLEEP;
         wakeen_reg <= '0;
         sleepcfg_reg <= `CLPM_RST_SLEEPCFG;
      end else begin
         if (wr_hit(`CLPM_OFS_RUNPWR))
            runpwr_reg <= wdata_i[2:0];
         if (wr_hit(`CLPM_OFS_PWRMODE))
            pwrmode_reg <= clpm_pkg::clpm_mode_t'(wdata_i[1:0]);
         if (wr_hit(`CLPM_OFS_WAKEEN))
            wakeen_reg <= wdata_i[3:0];
         if (wr_hit(`CLPM_OFS_SLEEPCFG))
            sleepcfg_reg <= wdata_i[2:0];
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_comb begin
      rdata_next = 32'h00000000;
      if (addr_i == `CLPM_OFS_FROCFG)
         rdata_next[2:0] = frocfg_reg;
      else if (addr_i == `CLPM_OFS_MAINSEL)
         rdata_next[2:0] = mainsel_reg;
      else if (addr_i == `CLPM_OFS_COREDIV)
         rdata_next[7:0] = corediv_reg;
      else if (addr_i == `CLPM_OFS_GATES)
         rdata_next[NPERIPH-1:0] = gates_reg;
      else if (addr_i == `CLPM_OFS_RUNPWR)
         rdata_next[2:0] = runpwr_reg;
      else if (addr_i == `CLPM_OFS_OUTSEL)
         rdata_next[2:0] = outsel_reg;
      else if (addr_i == `CLPM_OFS_PWRMODE)
         rdata_next[1:0] = pwrmode_reg;
      else if (addr_i == `CLPM_OFS_WAKEEN)
         rdata_next[3:0] = wakeen_reg;
      else if (addr_i == `CLPM_OFS_SLEEPCFG)
         rdata_next[2:0] = sleepcfg_reg;
      else if (addr_i == `CLPM_OFS_STATUS)
         rdata_next[5:0] = {cur_src_reg, state_reg, ext_clk_assigned_i};
      else if (addr_i == `CLPM_OFS_PERDIV)
         rdata_next[7:0] = perdiv_reg;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         rdata_o <= 32'h00000000;
      else if (rd_i)
         rdata_o <= rdata_next;
      else
         rdata_o <= 32'h00000000;
   end

   // ------------------------------------------------------------
   // power mode sequencing
   // ------------------------------------------------------------
   logic deep_wake;
   logic in_low;
   assign deep_wake = |(wake_int_i & wakeen_reg
      & wake_ctl_en_i);
   assign in_low = (state_reg == clpm_pkg::CLPM_ST_LOW);

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= clpm_pkg::CLPM_ST_RUN;
         settle_reg <= 4'h0;
      end else begin
         case (state_reg)
            clpm_pkg::CLPM_ST_RUN: begin
               if (sleep_req_i && pwrmode_reg == clpm_pkg::CLPM_MODE_SLEEP)
                  state_reg <= clpm_pkg::CLPM_ST_SLEEP;
               else if (sleep_req_i)
                  state_reg <= clpm_pkg::CLPM_ST_LOW;
            end
            clpm_pkg::CLPM_ST_SLEEP: begin
               if (any_int_i)
                  state_reg <= clpm_pkg::CLPM_ST_RUN;
            end
            clpm_pkg::CLPM_ST_LOW: begin
               if (deep_wake) begin
                  state_reg <= clpm_pkg::CLPM_ST_RESTORE;
                  settle_reg <= `CLPM_WAKE_SETTLE;
               end
            end
            default: begin
               if (settle_reg == 4'h0)
                  state_reg <= clpm_pkg::CLPM_ST_RUN;
               else
                  settle_reg <= settle_reg - 4'h1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // source enables and power outputs
   // ------------------------------------------------------------
   logic deep;
   logic pdown;
   logic lposc_run;
   logic fro_run;
   assign deep = in_low && pwrmode_reg == clpm_pkg::CLPM_MODE_DEEP;
   assign pdown = in_low && pwrmode_reg == clpm_pkg::CLPM_MODE_PDOWN;
   assign lposc_run = in_low ? sleepcfg_reg[`CLPM_SLEEPCFG_LPOSC_ON]
      : runpwr_reg[`CLPM_RUNPWR_LPOSC_ON];
   assign fro_run = pdown ? 1'b0
      : deep ? sleepcfg_reg[`CLPM_SLEEPCFG_FRO_ON]
      : !runpwr_reg[`CLPM_RUNPWR_FRO_OFF];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         power_o <= '{fro_on: 1'b1, fro_out_en: 1'b1, lposc_on: 1'b0,
            bod_on: 1'b0, analog_on: 1'b1, flash_on: 1'b1,
            flash_standby: 1'b0};
      else begin
         power_o.fro_on <= fro_run;
         power_o.fro_out_en <= fro_run && !in_low;
         power_o.lposc_on <= lposc_run;
         power_o.bod_on <= in_low ? sleepcfg_reg[`CLPM_SLEEPCFG_BOD_ON]
            : runpwr_reg[`CLPM_RUNPWR_BOD_ON];
         power_o.analog_on <= !in_low;
         // flash is either in standby (deep) or off (power-down)
         power_o.flash_on <= !in_low;
         power_o.flash_standby <= deep;
      end
   end

   // ------------------------------------------------------------
   // oscillator rate outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fro_rate_o <= 2'h1;
         fro_div2_o <= 1'b0;
      end else begin
         fro_rate_o <= frocfg_reg[1:0];
         fro_div2_o <= frocfg_reg[2];
      end
   end

   // ------------------------------------------------------------
   // clock multiplexers
   // ------------------------------------------------------------
   logic ext_tick;
   logic fro_tick;
   logic lposc_tick;
   logic frodiv_tick;
   assign ext_tick = ext_clk_tick_i && ext_clk_assigned_i;
   assign fro_tick = fro_tick_i && fro_run && !in_low;
   assign lposc_tick = lposc_tick_i && lposc_run;
   assign frodiv_tick = fro_tick && fro_half_reg;

   function automatic logic src_tick(input clpm_pkg::clpm_main_src_t s);
      case (s)
         clpm_pkg::CLPM_SRC_FRO: src_tick = fro_tick;
         clpm_pkg::CLPM_SRC_EXT: src_tick = ext_tick;
         clpm_pkg::CLPM_SRC_LPOSC: src_tick = lposc_tick;
         clpm_pkg::CLPM_SRC_FRODIV: src_tick = frodiv_tick;
         default: src_tick = 1'b0;
      endcase
   endfunction

   logic main_tick;
   logic core_tick;
   logic per_tick;
   assign main_tick = src_tick(cur_src_reg);
   assign core_tick = main_tick && (core_cnt_reg == 8'h00)
      && corediv_reg != 8'h00;
   assign per_tick = main_tick && (per_cnt_reg == 8'h00)
      && perdiv_reg != 8'h00;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cur_src_reg <= clpm_pkg::CLPM_SRC_FRO;
         fro_half_reg <= 1'b0;
      end else begin
         if (fro_tick)
            fro_half_reg <= !fro_half_reg;
         // switch only between enable pulses, so no partial period
         if (!main_tick && cur_src_reg != mainsel_reg)
            cur_src_reg <= mainsel_reg;
      end
   end

   // ------------------------------------------------------------
   // dividers and gated outputs
   // ------------------------------------------------------------
   // restart on rewrite, so a new ratio acts from the next tick
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_cnt_reg <= 8'h00;
         per_cnt_reg <= 8'h00;
      end else begin
         if (wr_hit(`CLPM_OFS_COREDIV))
            core_cnt_reg <= 8'h00;
         else if (main_tick)
            core_cnt_reg <= (core_cnt_reg == 8'h00)
               ? corediv_reg - 8'h01 : core_cnt_reg - 8'h01;
         if (wr_hit(`CLPM_OFS_PERDIV))
            per_cnt_reg <= 8'h00;
         else if (main_tick)
            per_cnt_reg <= (per_cnt_reg == 8'h00)
               ? perdiv_reg - 8'h01 : per_cnt_reg - 8'h01;
      end
   end

   // ------------------------------------------------------------
   // gated clock enables
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         core_clk_en_o <= 1'b0;
         main_clk_en_o <= 1'b0;
      end else begin
         core_clk_en_o <= core_tick
            && state_reg == clpm_pkg::CLPM_ST_RUN;
         main_clk_en_o <= main_tick && !in_low;
      end
   end

   // bit 0 runs from its own divider
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         periph_clk_en_o <= '0;
      else begin
         periph_clk_en_o[0] <= per_tick && gates_reg[0] && !in_low;
         for (int i = 1; i < NPERIPH; i++)
            periph_clk_en_o[i] <= main_tick && gates_reg[i]
               && !in_low;
      end
   end

   // ------------------------------------------------------------
   // clock output function
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         clock_output_function_o <= 1'b0;
      else begin
         case (outsel_reg)
            clpm_pkg::CLPM_OUT_FRO: clock_output_function_o <= fro_tick && clock_output_function_assigned_i;
            clpm_pkg::CLPM_OUT_LPOSC:
               clock_output_function_o <= lposc_tick && clock_output_function_assigned_i;
            clpm_pkg::CLPM_OUT_MAIN:
               clock_output_function_o <= main_tick && clock_output_function_assigned_i && !in_low;
            clpm_pkg::CLPM_OUT_EXT: clock_output_function_o <= ext_tick && clock_output_function_assigned_i;
            default: clock_output_function_o <= 1'b0;
         endcase
      end
   end

endmodule // clpm_ctrl

// [hdl/clpm_regs.svh]
/*
 register map and constants of the clock and low power mode controller.
 assumes inclusion by bare name; definitions only.
*/
`ifndef CLPM_REGS_SVH
`define CLPM_REGS_SVH

`define CLPM_ADDR_W 4
// register offsets (word index on the plain port)
`define CLPM_OFS_FROCFG 4'h0
`define CLPM_OFS_MAINSEL 4'h1
`define CLPM_OFS_COREDIV 4'h2
`define CLPM_OFS_GATES 4'h3
`define CLPM_OFS_RUNPWR 4'h4
`define CLPM_OFS_OUTSEL 4'h5
`define CLPM_OFS_PWRMODE 4'h6
`define CLPM_OFS_WAKEEN 4'h7
`define CLPM_OFS_SLEEPCFG 4'h8
`define CLPM_OFS_STATUS 4'h9
`define CLPM_OFS_PERDIV 4'hA
// field positions
`define CLPM_RUNPWR_FRO_OFF 0
`define CLPM_RUNPWR_LPOSC_ON 1
`define CLPM_RUNPWR_BOD_ON 2
`define CLPM_SLEEPCFG_LPOSC_ON 0
`define CLPM_SLEEPCFG_BOD_ON 1
`define CLPM_SLEEPCFG_FRO_ON 2
// reset values
`define CLPM_RST_FROCFG 3'h1
`define CLPM_RST_MAINSEL 3'h0
`define CLPM_RST_COREDIV 8'h01
`define CLPM_RST_RUNPWR 3'h0
`define CLPM_RST_OUTSEL 3'h0
`define CLPM_RST_SLEEPCFG 3'h0
`define CLPM_RST_PERDIV 8'h01
// timing: settle cycles before core clock release on wake
`define CLPM_WAKE_SETTLE 4'h3

`endif

// [hdl/clpm_pkg.sv]
/*
 types of the clock and low power mode controller.
 assumes nothing beyond a SystemVerilog compiler.
*/
package clpm_pkg;

   typedef enum logic [2:0] {
      CLPM_SRC_FRO = 3'h0,
      CLPM_SRC_EXT = 3'h1,
      CLPM_SRC_LPOSC = 3'h2,
      CLPM_SRC_FRODIV = 3'h3,
      CLPM_SRC_NONE = 3'h4
   } clpm_main_src_t;

   typedef enum logic [2:0] {
      CLPM_OUT_NONE = 3'h0,
      CLPM_OUT_FRO = 3'h1,
      CLPM_OUT_LPOSC = 3'h2,
      CLPM_OUT_MAIN = 3'h3,
      CLPM_OUT_EXT = 3'h4
   } clpm_out_src_t;

   typedef enum logic [1:0] {
      CLPM_MODE_SLEEP = 2'h0,
      CLPM_MODE_DEEP = 2'h1,
      CLPM_MODE_PDOWN = 2'h2
   } clpm_mode_t;

   // gray along run -> sleep -> low -> restore -> run
   typedef enum logic [1:0] {
      CLPM_ST_RUN = 2'b00,
      CLPM_ST_SLEEP = 2'b01,
      CLPM_ST_LOW = 2'b11,
      CLPM_ST_RESTORE = 2'b10
   } clpm_state_t;

   typedef struct packed {
      logic pin_int;
      logic wdt_int;
      logic touch_int;
      logic serial_slave_int;
   } clpm_wake_t;

   typedef struct packed {
      logic fro_on;
      logic fro_out_en;
      logic lposc_on;
      logic bod_on;
      logic analog_on;
      logic flash_on;
      logic flash_standby;
   } clpm_power_t;

endpackage

// [verification/clpm_ctrl_properties.sv]
/*
 concurrent checks on the clock and low power mode controller ports.
 assumes binding into clpm_ctrl; single clock domain on clk_i.
*/
`timescale 1ns/1ps
module clpm_ctrl_properties #(
   parameter int NPERIPH = 8
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic fro_tick_i,
   input wire logic lposc_tick_i,
   input wire logic ext_clk_tick_i,
   input wire logic core_clk_en_o,
   input wire logic main_clk_en_o,
   input wire logic [NPERIPH-1:0] periph_clk_en_o,
   input wire logic clock_output_function_o,
   input wire clpm_pkg::clpm_power_t power_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside read answer cycle");
   a_main_cause: assert property (main_clk_en_o |->
      $past(fro_tick_i || lposc_tick_i || ext_clk_tick_i))
      else $error("main clock pulse without source edge");
   a_core_in_main: assert property (core_clk_en_o |-> main_clk_en_o)
      else $error("core pulse outside main clock");
   a_periph_in_main: assert property (|periph_clk_en_o |->
      main_clk_en_o)
      else $error("peripheral pulse outside main clock");
   a_clock_output_function_cause: assert property (clock_output_function_o |->
      $past(fro_tick_i || lposc_tick_i || ext_clk_tick_i))
      else $error("clock output pulse without source edge");
   a_fro_out_on: assert property (power_o.fro_out_en |->
      power_o.fro_on)
      else $error("oscillator output on while oscillator off");
   a_flash_modes: assert property (
      !(power_o.flash_on && power_o.flash_standby))
      else $error("flash on and in standby");
   a_deep_stops: assert property (power_o.flash_standby |->
      !core_clk_en_o && !main_clk_en_o && periph_clk_en_o == '0)
      else $error("clock running in deep sleep");
   a_pdown_stops: assert property (
      !power_o.flash_on && !power_o.flash_standby
      |-> !core_clk_en_o && !main_clk_en_o && periph_clk_en_o == '0)
      else $error("clock running in power down");
   a_core_restored: assert property (core_clk_en_o |->
      power_o.flash_on && power_o.analog_on)
      else $error("core clock before power restored");
endmodule // clpm_ctrl_properties

// [verification/clpm_osc_model.sv]
/*
 oscillator and pin edge model feeding the clock controller.
 assumes run_i changes just after rising edges of clk_i.
*/
`timescale 1ns/1ps
module clpm_osc_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic fro_tick_o,
   output logic lposc_tick_o,
   output logic ext_tick_o
);
   logic [7:0] cnt_reg;
   // edges stand still outside a counting window
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) cnt_reg <= 8'h00;
      else if (!run_i) cnt_reg <= 8'h00;
      else cnt_reg <= cnt_reg + 8'h01;
   end
   assign fro_tick_o = run_i && (cnt_reg % 8'h03 == 8'h00);
   assign ext_tick_o = run_i && (cnt_reg % 8'h03 == 8'h01);
   assign lposc_tick_o = run_i && (cnt_reg % 8'h28 == 8'h00);
endmodule // clpm_osc_model

// [verification/tb_clpm_ctrl.sv]
/*
 self-checking bench of the clock and low power mode controller.
 assumes the oscillator model gives 40 fro, 40 ext, 3 lposc edges a window.
*/
`timescale 1ns/1ps
`include "clpm_regs.svh"
module tb_clpm_ctrl;
   typedef struct packed {
      logic [6:0] pm;
      logic [6:0] pv;
      logic [2:0] fr;
      logic [39:0] cn;
   } clpm_note_t;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
   logic ext_as = 1'b0, out_as = 1'b1, slp = 1'b0, any_int = 1'b0;
   logic snap = 1'b0, clr = 1'b0, rd_seen = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, g;
   clpm_pkg::clpm_wake_t wk = '0, wk_en = '0;
   logic [31:0] rdata;
   logic core, main, clock_output_function, fro_div2, ft, lt, et;
   logic [7:0] per;
   logic [1:0] fro_rate;
   clpm_pkg::clpm_power_t pwr;
   logic [2:0] fro_exp = 3'h1;
   logic [39:0] cnt = '0;
   logic [31:0] rq[$];
   clpm_note_t nq[$], nt;
   int n_errors = 0, cmp_count = 0, seed = 87;
   logic [2:0] t_src[7] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
   logic t_ext[7] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
   logic [2:0] t_pwr[7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2};
   logic [7:0] t_m[7] = '{8'h28, 8'h00, 8'h28, 8'h00, 8'h03, 8'h14, 8'h00};
   initial begin
      forever #12.5 clk = ~clk;
   end
   clpm_ctrl i_clpm_ctrl (.clk_i(clk), .rst_i(rst), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .fro_tick_i(ft), .lposc_tick_i(lt), .ext_clk_tick_i(et),
      .ext_clk_assigned_i(ext_as), .clock_output_function_assigned_i(out_as),
      .sleep_req_i(slp), .wake_int_i(wk), .wake_ctl_en_i(wk_en),
      .any_int_i(any_int), .core_clk_en_o(core), .main_clk_en_o(main),
      .periph_clk_en_o(per), .clock_output_function_o(clock_output_function), .power_o(pwr),
      .fro_rate_o(fro_rate), .fro_div2_o(fro_div2));
   clpm_osc_model i_clpm_osc_model (.clk_i(clk), .rst_i(rst), .run_i(run),
      .fro_tick_o(ft), .lposc_tick_o(lt), .ext_tick_o(et));
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      rq.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic note(input logic [6:0] pm, input logic [6:0] pv,
                       input logic [39:0] cn);
      @(posedge clk);
      snap <= 1'b1;
      nq.push_back('{pm, pv, fro_exp, cn});
      @(posedge clk);
      snap <= 1'b0;
   endtask
   // counts of main, core, clock_output_function, periph bit1, periph bit2 in a window
   task automatic win(input logic [7:0] m, c, o, p, q);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      run <= 1'b1;
      cyc(120);
      run <= 1'b0;
      cyc(4);
      note(7'h00, 7'h00, {m, c, o, p, q});
   endtask
   task automatic enter(input logic [1:0] md);
      wr_reg(`CLPM_OFS_PWRMODE, {30'h0, md});
      @(posedge clk);
      slp <= 1'b1;
      @(posedge clk);
      slp <= 1'b0;
      cyc(4);
   endtask
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      rd_seen <= rd;
      if (clr) cnt <= '0;
      else cnt <= cnt + {7'h0, main, 7'h0, core, 7'h0, clock_output_function,
                         7'h0, per[1], 7'h0, per[2]};
      if (rd_seen) chk("rdata", rq.pop_front(), rdata);
      if (snap) begin
         nt = nq.pop_front();
         chk("fro rate", nt.fr, {fro_div2, fro_rate});
         chk("power", nt.pv & nt.pm, pwr & nt.pm);
         for (int k = 0; k < 5; k++) begin
            if (nt.cn[k*8 +: 8] !== 8'hFF)
               chk("clock count", nt.cn[k*8 +: 8], cnt[k*8 +: 8]);
         end
      end
   end
   initial begin
      logic [7:0] p1, p2;
      logic [3:0] b;
      cyc(3);
      rst <= 1'b0;
      note(7'h7F, 7'b1100110, '1);
      rd_reg(`CLPM_OFS_MAINSEL, 32'h0);
      rd_reg(`CLPM_OFS_FROCFG, 32'h1);
      rd_reg(`CLPM_OFS_COREDIV, 32'h1);
      rd_reg(`CLPM_OFS_GATES, 32'hFF);
      wr_reg(4'hF, $random(seed));
      rd_reg(4'hF, 32'h0);
      win(8'h28, 8'h28, 8'h00, 8'hFF, 8'hFF);
      for (int i = 0; i < 6; i++) begin
         fro_exp = {i[0], 2'(i >> 1)};
         wr_reg(`CLPM_OFS_FROCFG, {29'h0, fro_exp});
         cyc(2);
         note(7'h00, 7'h00, '1);
      end
      fro_exp = 3'h1;
      wr_reg(`CLPM_OFS_FROCFG, 32'h1);
      g = $random(seed);
      wr_reg(`CLPM_OFS_GATES, g);
      wr_reg(`CLPM_OFS_OUTSEL, 32'h3);
      for (int i = 0; i < 7; i++) begin
         ext_as <= t_ext[i];
         wr_reg(`CLPM_OFS_RUNPWR, {29'h0, t_pwr[i]});
         wr_reg(`CLPM_OFS_MAINSEL, {29'h0, t_src[i]});
         win(t_m[i], t_m[i], t_m[i], g[1] ? t_m[i] : 8'h00,
             g[2] ? t_m[i] : 8'h00);
         rd_reg(`CLPM_OFS_STATUS, {26'h0, t_src[i], 2'b00, t_ext[i]});
      end
      wr_reg(`CLPM_OFS_MAINSEL, 32'h0);
      p1 = g[1] ? 8'h28 : 8'h00;
      p2 = g[2] ? 8'h28 : 8'h00;
      wr_reg(`CLPM_OFS_COREDIV, 32'h2);
      win(8'h28, 8'h14, 8'h28, p1, p2);
      wr_reg(`CLPM_OFS_COREDIV, 32'h0);
      win(8'h28, 8'h00, 8'h28, p1, p2);
      wr_reg(`CLPM_OFS_COREDIV, 32'h1);
      enter(2'h0);
      win(8'h28, 8'h00, 8'h28, p1, p2);
      any_int <= 1'b1;
      cyc(8);
      any_int <= 1'b0;
      win(8'h28, 8'h28, 8'h28, p1, p2);
      wr_reg(`CLPM_OFS_SLEEPCFG, 32'h7);
      for (int i = 0; i < 8; i++) begin
         b = 4'h1 << (i % 4);
         wr_reg(`CLPM_OFS_WAKEEN, {28'h0, b});
         enter(i < 4 ? 2'h1 : 2'h2);
         wk <= b;
         note(7'h7F, i < 4 ? 7'b1011001 : 7'b0011000, '1);
         win(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
         wk_en <= b;
         cyc(10);
         wk <= '0;
         wk_en <= '0;
         note(7'h7F, 7'b1110110, '1);
         win(8'h28, 8'h28, 8'h28, p1, p2);
      end
      for (int k = 0; k < 20 && (rq.size() + nq.size()) > 0; k++) cyc(1);
      if ((rq.size() + nq.size()) > 0) n_errors++;
      print_verdict();
   end
endmodule // tb_clpm_ctrl
bind clpm_ctrl clpm_ctrl_properties #(.NPERIPH(NPERIPH))
   i_clpm_ctrl_properties (
   .clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .fro_tick_i(fro_tick_i), .lposc_tick_i(lposc_tick_i),
   .ext_clk_tick_i(ext_clk_tick_i), .core_clk_en_o(core_clk_en_o),
   .main_clk_en_o(main_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
   .clock_output_function_o(clock_output_function_o), .power_o(power_o));
